// file: include/crg_pkg.sv
// Register map, field layout and carrier types of the codec routing and gain bank
package crg_pkg;

  // APB byte addresses of the two shared sub-register addresses
  localparam logic [7:0] GAIN_ADDR = 8'h14;
  localparam logic [7:0] ROUTE_ADDR = 8'h18;
  // Read-only aliases that show each sub-register without a prior select write
  localparam logic [7:0] DAC_VIEW_ADDR = 8'h20;
  localparam logic [7:0] SIDE_VIEW_ADDR = 8'h24;
  localparam logic [7:0] SPK_VIEW_ADDR = 8'h28;
  localparam logic [7:0] IN_VIEW_ADDR = 8'h2C;
  localparam logic [7:0] OUT_VIEW_ADDR = 8'h30;

  // Sub-register tags in D7-D6 of the gain address
  localparam logic [1:0] TAG_UNUSED = 2'h0;
  localparam logic [1:0] TAG_DAC = 2'h1;
  localparam logic [1:0] TAG_SIDE = 2'h2;
  localparam logic [1:0] TAG_SPK = 2'h3;
  // Sub-register tags in D7 of the routing address
  localparam logic TAG_IN = 1'b0;
  localparam logic TAG_OUT = 1'b1;

  // Field positions inside the written byte
  localparam int GAIN_TAG_LSB = 6;
  localparam int ROUTE_TAG_BIT = 7;
  localparam int DAC_LSB = 0;
  localparam int ANA_SIDE_LSB = 3;
  localparam int DIG_SIDE_LSB = 0;
  localparam int SPK_LSB = 4;
  localparam int SPK_RSVD_LSB = 0;
  localparam int OUT_RSVD_BIT = 6;

  // Field widths
  localparam int DAC_W = 6;
  localparam int SIDE_W = 3;
  localparam int SPK_W = 2;
  localparam int RSVD_W = 4;
  localparam int IN_W = 7;
  localparam int OUT_W = 6;
  localparam int ATTEN_W = 8;

  // Reset values
  localparam logic [DAC_W-1:0] DAC_RST = 6'h00;
  localparam logic [SIDE_W-1:0] SIDE_RST = 3'h0;
  localparam logic [SPK_W-1:0] SPK_RST = 2'h0;
  localparam logic [RSVD_W-1:0] RSVD_RST = 4'h0;
  localparam logic [IN_W-1:0] IN_RST = 7'h00;
  localparam logic [OUT_W-1:0] OUT_RST = 6'h00;

  // Attenuation decoders, in 0.5 dB units: DAC, analog sidetone, digital sidetone
  localparam int DEC_N = 3;
  localparam int DAC_BASE = 0;
  localparam int DAC_STEP = 3;
  localparam int SIDE_BASE = 18;
  localparam int SIDE_STEP = 6;

  typedef struct packed {
    logic headset_loopback;
    logic handset_loopback;
    logic caller_input_sel;
    logic line_input_sel;
    logic microphone_input_sel;
    logic handset_input_sel;
    logic headset_input_sel;
  } crg_in_route_s;

  typedef struct packed {
    logic sidetone_to_headset;
    logic sidetone_to_handset;
    logic speaker_output_sel;
    logic line_output_sel;
    logic handset_output_sel;
    logic headset_output_sel;
  } crg_out_route_s;

  typedef struct packed {
    logic [ATTEN_W-1:0] atten_half_db;
    logic mute;
  } crg_atten_s;

endpackage

// file: hdl/crg_step_dec.sv
// Registered decoder from a gain code to attenuation in half-dB steps
`timescale 1ns/1ps
module crg_step_dec #(
  parameter int CODE_W = 3,
  parameter int BASE = 18,
  parameter int STEP = 6,
  parameter bit MUTE_EN = 1'b1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [CODE_W-1:0] code_i,
  output crg_pkg::crg_atten_s atten_o
);

  initial begin
    if (BASE + (2**CODE_W - 1) * STEP >= 2**crg_pkg::ATTEN_W) begin
      $error("crg_step_dec: attenuation range exceeds output width");
    end
  end

  crg_pkg::crg_atten_s state;
  crg_pkg::crg_atten_s next_state;

  always_comb begin
    next_state.atten_half_db = crg_pkg::ATTEN_W'(BASE + int'(code_i) * STEP);
    next_state.mute = MUTE_EN && (&code_i);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign atten_o = state;

endmodule

// file: hdl/crg_regs.sv
// APB register bank for codec sidetone, speaker, DAC gain and analog routing
// Operation
// - DAC gain code 0 gives 0 dB, each step adds 1.5 dB attenuation.
// - Analog sidetone D5-D3: 000 is -9 dB, 3 dB steps, 111 mutes.
// - Digital sidetone D2-D0: 000 is -9 dB, 3 dB steps, 111 mutes.
// - Speaker gain D5-D4 resets 00, codes select 0 to 3 dB gain.
// - Input routing D6 loops headset input to headset output; resets zero.
// - Input routing D5 loops handset input to handset output; resets zero.
// - Input routing D4 routes caller ID input to ADC; resets zero.
// - Input routing D3 routes line input to ADC; resets zero.
// - Input routing D2 routes microphone input to ADC; resets zero.
// - Input routing D1 routes handset input to ADC; resets zero.
// - Input routing D0 routes headset input to ADC; resets zero.
// - Speaker register D3-D0 are reserved, reset to 0000.
// - Output routing D5/D4 send analog sidetone to headset/handset; reset zero.
// - Output routing D3 connects DAC to speaker driver; resets zero.
// - Output routing D2 connects DAC to line driver; resets zero.
// - Output routing D1/D0 connect DAC to handset/headset driver; reset zero.
`timescale 1ns/1ps
module crg_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output crg_pkg::crg_in_route_s in_route_o,
  output crg_pkg::crg_out_route_s out_route_o,
  output crg_pkg::crg_atten_s dac_atten_o,
  output crg_pkg::crg_atten_s analog_side_o,
  output crg_pkg::crg_atten_s digital_side_o,
  output logic [crg_pkg::SPK_W-1:0] speaker_gain_code_o
);

  initial begin
    if (ADDR_W < 8) begin
      $error("crg_regs: ADDR_W must cover the register map");
    end
  end

  typedef struct packed {
    logic [crg_pkg::DAC_W-1:0] dac_gain;
    logic [crg_pkg::SIDE_W-1:0] analog_side_gain;
    logic [crg_pkg::SIDE_W-1:0] digital_side_gain;
    logic [crg_pkg::SPK_W-1:0] speaker_gain_code;
    logic [crg_pkg::RSVD_W-1:0] speaker_rsvd;
    crg_pkg::crg_in_route_s in_route;
    crg_pkg::crg_out_route_s out_route;
    logic [1:0] gain_rd_tag;
    logic route_rd_tag;
    logic [31:0] rdata;
    logic slverr;
  } crg_state_s;

  crg_state_s state;
  crg_state_s next_state;

  logic setup_phase;
  logic access_wr;
  logic byte0_wr;
  logic [7:0] wbyte;
  logic [7:0] addr8;
  logic [1:0] gain_tag;
  logic route_tag;
  logic [7:0] dac_byte;
  logic [7:0] side_byte;
  logic [7:0] spk_byte;
  logic [7:0] in_byte;
  logic [7:0] out_byte;
  logic [7:0] gain_byte;
  logic [7:0] route_byte;
  logic [7:0] rd_byte;
  logic addr_hit;
  logic addr_ro;

  assign setup_phase = psel_i && !penable_i;
  // A write lands only at the access edge, when the master samples pready
  assign access_wr = psel_i && penable_i && pwrite_i;
  // All fields live in lane 0; a write without that lane changes nothing
  assign byte0_wr = access_wr && pstrb_i[0];
  assign wbyte = pwdata_i[7:0];
  assign addr8 = paddr_i[7:0];
  assign gain_tag = wbyte[crg_pkg::GAIN_TAG_LSB +: 2];
  assign route_tag = wbyte[crg_pkg::ROUTE_TAG_BIT];

  // Read images carry their tag bits so a read byte can be written back as is
  always_comb begin
    dac_byte = '0;
    dac_byte[crg_pkg::GAIN_TAG_LSB +: 2] = crg_pkg::TAG_DAC;
    dac_byte[crg_pkg::DAC_LSB +: crg_pkg::DAC_W] = state.dac_gain;
    side_byte = '0;
    side_byte[crg_pkg::GAIN_TAG_LSB +: 2] = crg_pkg::TAG_SIDE;
    side_byte[crg_pkg::ANA_SIDE_LSB +: crg_pkg::SIDE_W] = state.analog_side_gain;
    side_byte[crg_pkg::DIG_SIDE_LSB +: crg_pkg::SIDE_W] = state.digital_side_gain;
    spk_byte = '0;
    spk_byte[crg_pkg::GAIN_TAG_LSB +: 2] = crg_pkg::TAG_SPK;
    spk_byte[crg_pkg::SPK_LSB +: crg_pkg::SPK_W] = state.speaker_gain_code;
    spk_byte[crg_pkg::SPK_RSVD_LSB +: crg_pkg::RSVD_W] = state.speaker_rsvd;
    in_byte = '0;
    in_byte[crg_pkg::ROUTE_TAG_BIT] = crg_pkg::TAG_IN;
    in_byte[crg_pkg::IN_W-1:0] = state.in_route;
    out_byte = '0;
    out_byte[crg_pkg::ROUTE_TAG_BIT] = crg_pkg::TAG_OUT;
    out_byte[crg_pkg::OUT_RSVD_BIT] = 1'b0;
    out_byte[crg_pkg::OUT_W-1:0] = state.out_route;
  end

  // The shared addresses read back the sub-register last selected by a write
  always_comb begin
    unique case (state.gain_rd_tag)
      crg_pkg::TAG_DAC: gain_byte = dac_byte;
      crg_pkg::TAG_SIDE: gain_byte = side_byte;
      crg_pkg::TAG_SPK: gain_byte = spk_byte;
      default: gain_byte = 8'h00;
    endcase
    route_byte = state.route_rd_tag ? out_byte : in_byte;
  end

  always_comb begin
    addr_hit = 1'b1;
    addr_ro = 1'b0;
    rd_byte = 8'h00;
    unique case (addr8)
      crg_pkg::GAIN_ADDR: rd_byte = gain_byte;
      crg_pkg::ROUTE_ADDR: rd_byte = route_byte;
      crg_pkg::DAC_VIEW_ADDR: begin
        rd_byte = dac_byte;
        addr_ro = 1'b1;
      end
      crg_pkg::SIDE_VIEW_ADDR: begin
        rd_byte = side_byte;
        addr_ro = 1'b1;
      end
      crg_pkg::SPK_VIEW_ADDR: begin
        rd_byte = spk_byte;
        addr_ro = 1'b1;
      end
      crg_pkg::IN_VIEW_ADDR: begin
        rd_byte = in_byte;
        addr_ro = 1'b1;
      end
      crg_pkg::OUT_VIEW_ADDR: begin
        rd_byte = out_byte;
        addr_ro = 1'b1;
      end
      default: addr_hit = 1'b0;
    endcase
    if (ADDR_W > 8 && paddr_i[ADDR_W-1:0] != ADDR_W'(addr8)) begin
      addr_hit = 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    // Read data and error are captured in the setup cycle, so both come from flops
    if (setup_phase) begin
      next_state.rdata = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      next_state.slverr = !addr_hit || (pwrite_i && addr_ro);
    end
    if (byte0_wr && addr_hit && !addr_ro) begin
      if (addr8 == crg_pkg::GAIN_ADDR) begin
        next_state.gain_rd_tag = gain_tag;
        unique case (gain_tag)
          crg_pkg::TAG_DAC: begin
            next_state.dac_gain = wbyte[crg_pkg::DAC_LSB +: crg_pkg::DAC_W];
          end
          crg_pkg::TAG_SIDE: begin
            next_state.analog_side_gain = wbyte[crg_pkg::ANA_SIDE_LSB +: crg_pkg::SIDE_W];
            next_state.digital_side_gain = wbyte[crg_pkg::DIG_SIDE_LSB +: crg_pkg::SIDE_W];
          end
          crg_pkg::TAG_SPK: begin
            next_state.speaker_gain_code = wbyte[crg_pkg::SPK_LSB +: crg_pkg::SPK_W];
            next_state.speaker_rsvd = wbyte[crg_pkg::SPK_RSVD_LSB +: crg_pkg::RSVD_W];
          end
          default: begin
            // No sub-register behind this tag here; the write is dropped
          end
        endcase
      end else begin
        next_state.route_rd_tag = route_tag;
        if (route_tag == crg_pkg::TAG_OUT) begin
          // D6 is not stored at all, so it can never read back as one
          next_state.out_route = wbyte[crg_pkg::OUT_W-1:0];
        end else begin
          next_state.in_route = wbyte[crg_pkg::IN_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state.dac_gain <= crg_pkg::DAC_RST;
      state.analog_side_gain <= crg_pkg::SIDE_RST;
      state.digital_side_gain <= crg_pkg::SIDE_RST;
      state.speaker_gain_code <= crg_pkg::SPK_RST;
      state.speaker_rsvd <= crg_pkg::RSVD_RST;
      state.in_route <= crg_pkg::IN_RST;
      state.out_route <= crg_pkg::OUT_RST;
      state.gain_rd_tag <= crg_pkg::TAG_UNUSED;
      state.route_rd_tag <= crg_pkg::TAG_IN;
      state.rdata <= 32'h0000_0000;
      state.slverr <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Zero wait states: every access phase completes in its first cycle
  assign pready_o = 1'b1;
  assign prdata_o = state.rdata;
  assign pslverr_o = state.slverr && psel_i && penable_i;

  assign in_route_o = state.in_route;
  assign out_route_o = state.out_route;
  assign speaker_gain_code_o = state.speaker_gain_code;

  // Three code-to-attenuation decoders share one registered structure
  localparam int DEC_CW [crg_pkg::DEC_N] = '{crg_pkg::DAC_W, crg_pkg::SIDE_W, crg_pkg::SIDE_W};
  localparam int DEC_BASE [crg_pkg::DEC_N] = '{crg_pkg::DAC_BASE, crg_pkg::SIDE_BASE, crg_pkg::SIDE_BASE};
  localparam int DEC_STEP [crg_pkg::DEC_N] = '{crg_pkg::DAC_STEP, crg_pkg::SIDE_STEP, crg_pkg::SIDE_STEP};
  localparam bit DEC_MUTE [crg_pkg::DEC_N] = '{1'b0, 1'b1, 1'b1};

  logic [crg_pkg::DAC_W-1:0] dec_code [crg_pkg::DEC_N];
  crg_pkg::crg_atten_s dec_out [crg_pkg::DEC_N];

  assign dec_code[0] = state.dac_gain;
  assign dec_code[1] = crg_pkg::DAC_W'(state.analog_side_gain);
  assign dec_code[2] = crg_pkg::DAC_W'(state.digital_side_gain);

  for (genvar g = 0; g < crg_pkg::DEC_N; g++) begin : gen_dec
    crg_step_dec #(
      .CODE_W(DEC_CW[g]),
      .BASE(DEC_BASE[g]),
      .STEP(DEC_STEP[g]),
      .MUTE_EN(DEC_MUTE[g])
    ) u_dec (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .code_i(dec_code[g][DEC_CW[g]-1:0]),
      .atten_o(dec_out[g])
    );
  end

  assign dac_atten_o = dec_out[0];
  assign analog_side_o = dec_out[1];
  assign digital_side_o = dec_out[2];

endmodule

// file: tb/crg_regs_asserts.sv
// Port-level checks of the routing and gain register bank
`timescale 1ns/1ps
module crg_regs_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire crg_pkg::crg_in_route_s in_route_o,
  input wire crg_pkg::crg_out_route_s out_route_o,
  input wire crg_pkg::crg_atten_s dac_atten_o,
  input wire crg_pkg::crg_atten_s analog_side_o,
  input wire crg_pkg::crg_atten_s digital_side_o,
  input wire logic [crg_pkg::SPK_W-1:0] speaker_gain_code_o
);
  logic acc;
  logic wr;
  logic wg;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i && pstrb_i[0] && paddr_i == crg_pkg::ROUTE_ADDR;
  assign wg = acc && pwrite_i && pstrb_i[0] && paddr_i == crg_pkg::GAIN_ADDR;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_IN_WR: assert property (wr && !pwdata_i[7] |=> in_route_o == $past(pwdata_i[6:0]))
    else $error("input routing write lost");
  AST_OUT_WR: assert property (wr && pwdata_i[7] |=> out_route_o == $past(pwdata_i[5:0]))
    else $error("output routing write lost");
  AST_SPK_WR: assert property (wg && pwdata_i[7:6] == 2'h3 |=> speaker_gain_code_o == $past(pwdata_i[5:4]))
    else $error("speaker gain write lost");
  // Decoders lag the register by one clock
  AST_DAC_DEC: assert property (wg && pwdata_i[7:6] == 2'h1 |-> ##2
    dac_atten_o == {8'(3 * $past(pwdata_i[5:0], 2)), 1'b0}) else $error("dac attenuation wrong");
  AST_ANA_DEC: assert property (wg && pwdata_i[7:6] == 2'h2 |-> ##2
    analog_side_o == {8'(18 + 6 * $past(pwdata_i[5:3], 2)), $past(pwdata_i[5:3], 2) == 3'h7})
    else $error("analog sidetone decode wrong");
  AST_DIG_DEC: assert property (wg && pwdata_i[7:6] == 2'h2 |-> ##2
    digital_side_o == {8'(18 + 6 * $past(pwdata_i[2:0], 2)), $past(pwdata_i[2:0], 2) == 3'h7})
    else $error("digital sidetone decode wrong");
  AST_TAG_DROP: assert property (wg && pwdata_i[7:6] == 2'h0 |=>
    $stable(speaker_gain_code_o) && $stable(analog_side_o)) else $error("untagged write took effect");
  AST_OUT_RD: assert property (acc && !pwrite_i && paddr_i == crg_pkg::OUT_VIEW_ADDR |->
    prdata_o == {24'h0, 2'b10, out_route_o}) else $error("output routing read wrong");
  AST_RST: assert property ($rose(rst_n_i) |-> {in_route_o, out_route_o, speaker_gain_code_o} == 15'h0)
    else $error("controls not cleared by reset");
  cover property (wg && pwdata_i[7:6] == 2'h2 && pwdata_i[5:3] == 3'h7);
  cover property (pslverr_o);
  cover property (acc && !pwrite_i && paddr_i == crg_pkg::OUT_VIEW_ADDR);
endmodule

bind crg_regs crg_regs_asserts #(.ADDR_W(ADDR_W)) u_crg_chk (
  .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
  .pslverr_o, .in_route_o, .out_route_o, .dac_atten_o, .analog_side_o, .digital_side_o, .speaker_gain_code_o
);

// file: tb/tb_codec_routing_gain_regs.sv
// Self-checking bench for the routing and gain register bank
`timescale 1ns/1ps
module tb_codec_routing_gain_regs;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdat;
    logic [7:0] rexp;
    logic [14:0] outs;
  } crg_row_s;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  crg_pkg::crg_in_route_s in_route_o;
  crg_pkg::crg_out_route_s out_route_o;
  crg_pkg::crg_atten_s dac_atten_o;
  crg_pkg::crg_atten_s analog_side_o;
  crg_pkg::crg_atten_s digital_side_o;
  logic [1:0] speaker_gain_code_o;
  logic [31:0] rdat;
  logic rerr;
  int failures = 0;
  int num_checks = 0;

  crg_regs DUT (.clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
    .pready_o, .pslverr_o, .in_route_o, .out_route_o, .dac_atten_o, .analog_side_o, .digital_side_o,
    .speaker_gain_code_o);

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Entered just after an edge; returns one idle cycle after the access so calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'hA5A5A5, d};
    pstrb_i <= s;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00, 4'hF);
  endtask

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // The decoders load code 0 at the first edge after release; look one edge later so that load has settled
    @(posedge clock_i);
    @(posedge clock_i);
    chk("ctrl", {17'h0, in_route_o, out_route_o, speaker_gain_code_o}, 32'h0);
    chk("side", {23'h0, analog_side_o}, {23'h0, 8'd18, 1'b0});
  endtask

  initial begin : main
    crg_row_s rows [8];
    int dc [3];
    dc = '{0, 1, 63};
    rows = '{'{8'h18, 8'h55, 8'h55, 15'h5500}, '{8'h18, 8'h2A, 8'h2A, 15'h2A00},
      '{8'h18, 8'hFF, 8'hBF, 15'h2AFC}, '{8'h18, 8'h95, 8'h95, 15'h2A54},
      '{8'h14, 8'hF0, 8'hF0, 15'h2A57}, '{8'h14, 8'hE5, 8'hE5, 15'h2A56},
      '{8'h14, 8'h7F, 8'h7F, 15'h2A56}, '{8'h18, 8'h7F, 8'h7F, 15'h7F56}};
    do_reset();
    rd(crg_pkg::GAIN_ADDR);
    chk("gain reset", rdat, 32'h0);
    rd(crg_pkg::OUT_VIEW_ADDR);
    chk("out reset", rdat, 32'h80);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdat);
      chk("ctrl", {17'h0, in_route_o, out_route_o, speaker_gain_code_o}, {17'h0, rows[i].outs});
      rd(rows[i].addr);
      chk("readback", rdat, {24'h0, rows[i].rexp});
    end
    for (int c = 0; c < 8; c++) begin
      wr(crg_pkg::GAIN_ADDR, {2'b10, 3'(c), 3'(7 - c)});
      @(posedge clock_i);
      chk("analog", {23'h0, analog_side_o}, {23'h0, 8'(18 + 6 * c), c == 7});
      chk("digital", {23'h0, digital_side_o}, {23'h0, 8'(18 + 6 * (7 - c)), c == 0});
    end
    foreach (dc[i]) begin
      wr(crg_pkg::GAIN_ADDR, {2'b01, 6'(dc[i])});
      @(posedge clock_i);
      chk("dac", {23'h0, dac_atten_o}, {23'h0, 8'(3 * dc[i]), 1'b0});
    end
    wr(crg_pkg::GAIN_ADDR, 8'h3F);
    chk("drop err", {31'h0, rerr}, 32'h0);
    apb(1'b1, crg_pkg::ROUTE_ADDR, 8'h00, 4'hE);
    wr(crg_pkg::IN_VIEW_ADDR, 8'h00);
    chk("view err", {31'h0, rerr}, 32'h1);
    chk("ctrl", {17'h0, in_route_o, out_route_o, speaker_gain_code_o}, 32'h7F56);
    rd(8'h04);
    chk("unmapped", {rdat[30:0], rerr}, 32'h1);
    do_reset();
    report_and_stop();
  end
endmodule
